// [common/rx_sig_counters_cfg.svh]
`ifndef RX_SIG_COUNTERS_CFG_SVH
`define RX_SIG_COUNTERS_CFG_SVH

// ==================================================
// register indices (byte address = 4 * index)
`define MW_ENABLE_1_IDX 9'h03C
`define MW_ENABLE_2_IDX 9'h03D
`define MW_ENABLE_3_IDX 9'h03E
`define SIG_FIRST_IDX 9'h040
`define SIG_LAST_IDX 9'h04F
`define LINE_VIOL_HI_IDX 9'h050
`define LINE_VIOL_LO_IDX 9'h051
`define PATH_VIOL_HI_IDX 9'h052
`define PATH_VIOL_LO_IDX 9'h053
`define FRAME_SLIP_HI_IDX 9'h054
`define FRAME_SLIP_LO_IDX 9'h055
`define EBIT_HI_IDX 9'h056
`define EBIT_LO_IDX 9'h057
`define REMOTE_A_HI_IDX 9'h058
`define REMOTE_A_LO_IDX 9'h059
`define MODE_CTRL_IDX 9'h070
`define IRQ_STATUS_IDX 9'h071
`define IRQ_MASK_IDX 9'h072

// ==================================================
// port stride in register indices
`define PORT_STRIDE 12'h200

// ==================================================
// field positions
`define MODE_E1_BIT 0
`define MODE_ESF_BIT 1
`define IRQ_SIG_UPDATE_BIT 0
`define IRQ_SYNC_LOSS_BIT 1
`define IRQ_SATURATE_BIT 2

// ==================================================
// reset values
`define MODE_CTRL_RST 8'h00
`define IRQ_MASK_RST 8'h00
`define COUNT_RST 16'h0000
`define SIG_RST 8'h00

// ==================================================
// digital milliwatt code, eight-byte cycle
`define MW_CODE_0 8'h1E
`define MW_CODE_1 8'h0B
`define MW_CODE_2 8'h0B
`define MW_CODE_3 8'h1E
`define MW_CODE_4 8'h9E
`define MW_CODE_5 8'h8B
`define MW_CODE_6 8'h8B
`define MW_CODE_7 8'h9E

`endif

// [common/rx_sig_counters_pkg.sv]
`include "rx_sig_counters_cfg.svh"

package rx_sig_counters_pkg;

   typedef struct packed {
      logic [15:0][7:0] sig;
      logic [4:0][15:0] cnt;
      logic [23:0] mw_en;
      logic [7:0] mode;
      logic [7:0] irq_status;
      logic [7:0] irq_mask;
      logic [7:0] lo_shadow;
      logic [2:0] mw_phase;
      logic [31:0] readdata;
      logic waitrequest;
      logic irq;
      logic [7:0] rx_data_out;
      logic rx_data_out_valid;
      logic sync_lost_d;
   } core_state_t;

endpackage

// [core/rx_sig_counters.sv]
// Notes on behaviour
// - Each set T1 milliwatt enable bit replaces that channel's receive byte with the milliwatt code.
// - The sixteen signaling bytes sit at 040h to 04Fh, repeated per port at a 200h stride.
// - In T1 mode store k carries channel k ABCD high and channel k+12 ABCD low, A first.
// - In E1 mode store 1 reads zero high with spare bits low; store k has channels k-1 and k+14.
// - With extended superframe framing all four signaling bits A, B, C, D are captured.
// - With D4 framing the received A and B are copied into the C and D positions.
// - While the framer is out of sync the signaling store is frozen at its last values.
// - A 16-bit line violation tally reads high at 050h and low at 051h, reset zero.
// - A 16-bit path violation tally reads high at 052h and low at 053h, reset zero.
// - A 16-bit frame slip tally reads high at 054h and low at 055h, reset zero.
// - In E1 mode only a 16-bit E-bit tally reads high at 056h and low at 057h, reset zero.
// - A 16-bit remote error A tally has its high byte at 058h, reset zero.
// - The remote error A tally low byte reads at 059h, reset zero.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

module rx_sig_counters #(
   parameter int PORT_ID = 0,
   parameter int NUM_CHANNELS = 24
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic sig_valid,
   input wire logic [4:0] sig_channel,
   input wire logic [3:0] sig_abcd,
   input wire logic sync_lost,
   input wire logic line_violation_evt,
   input wire logic path_violation_evt,
   input wire logic frame_slip_evt,
   input wire logic far_error_bit_evt,
   input wire logic remote_error_a_evt,
   input wire logic rx_data_valid,
   input wire logic [4:0] rx_data_channel,
   input wire logic [7:0] rx_data_in,
   output logic [7:0] rx_data_out,
   output logic rx_data_out_valid
);

   // ==================================================
   // elaboration checks
   generate
      if (PORT_ID < 0 || PORT_ID > 7) begin : g_bad_port
         $error("PORT_ID must be 0 to 7");
      end
      if (NUM_CHANNELS != 24) begin : g_bad_chan
         $error("milliwatt enables serve exactly 24 channels");
      end
   endgenerate

   localparam logic [2:0] PORT_SEL = 3'(PORT_ID);

   rx_sig_counters_pkg::core_state_t cur_ff;
   rx_sig_counters_pkg::core_state_t nxt_cur;

   // ==================================================
   // decode helpers
   function automatic logic port_hit(input logic [13:0] addr);
      port_hit = (addr[13:11] == PORT_SEL);
   endfunction

   function automatic logic [8:0] reg_idx(input logic [13:0] addr);
      reg_idx = addr[10:2];
   endfunction

   // store index and nibble (1 = high) for a channel
   function automatic logic [4:0] sig_slot(input logic [4:0] ch, input logic e1);
      logic [3:0] idx;
      logic hi;
      idx = 4'h0;
      hi = 1'b0;
      if (!e1) begin
         if (ch >= 5'h01 && ch <= 5'h0C) begin
            idx = 4'(ch - 5'h01);
            hi = 1'b1;
         end else begin
            idx = 4'(ch - 5'h0D);
            hi = 1'b0;
         end
      end else begin
         if (ch == 5'h00) begin
            idx = 4'h0;
            hi = 1'b0;
         end else if (ch <= 5'h0F) begin
            idx = 4'(ch);
            hi = 1'b1;
         end else begin
            idx = 4'(ch - 5'h0F);
            hi = 1'b0;
         end
      end
      sig_slot = {hi, idx};
   endfunction

   function automatic logic sig_ch_ok(input logic [4:0] ch, input logic e1);
      if (e1) begin
         sig_ch_ok = (ch <= 5'h1E);
      end else begin
         sig_ch_ok = (ch >= 5'h01 && ch <= 5'h18);
      end
   endfunction

   function automatic logic [7:0] mw_code(input logic [2:0] ph);
      case (ph)
         3'h0: mw_code = `MW_CODE_0;
         3'h1: mw_code = `MW_CODE_1;
         3'h2: mw_code = `MW_CODE_2;
         3'h3: mw_code = `MW_CODE_3;
         3'h4: mw_code = `MW_CODE_4;
         3'h5: mw_code = `MW_CODE_5;
         3'h6: mw_code = `MW_CODE_6;
         default: mw_code = `MW_CODE_7;
      endcase
   endfunction

   // ==================================================
   // event vector, one entry per tally
   logic [4:0] tally_evt;
   logic e1_mode;
   logic esf_mode;
   logic [4:0] slot;
   logic [3:0] nib;
   logic [8:0] ridx;
   logic hit;
   logic acc_now;
   logic [7:0] rd_byte;
   logic [7:0] irq_set;
   logic sat_hit;
   logic sig_take;

   assign e1_mode = cur_ff.mode[`MODE_E1_BIT];
   assign esf_mode = cur_ff.mode[`MODE_ESF_BIT];
   assign tally_evt = {remote_error_a_evt, far_error_bit_evt & e1_mode, frame_slip_evt,
                       path_violation_evt, line_violation_evt};
   assign ridx = reg_idx(avs_address);
   assign hit = port_hit(avs_address);
   // request completes at the edge where waitrequest is sampled low
   assign acc_now = (avs_read | avs_write) & ~cur_ff.waitrequest;
   assign slot = sig_slot(sig_channel, e1_mode);
   assign sig_take = sig_valid & ~sync_lost & sig_ch_ok(sig_channel, e1_mode);

   // ==================================================
   // next state
   always_comb begin
      nxt_cur = cur_ff;
      irq_set = 8'h00;
      sat_hit = 1'b0;
      rd_byte = 8'h00;
      nib = 4'h0;

      if (esf_mode || e1_mode || sig_channel == 5'h00) begin
         nib = sig_abcd;
      end else begin
         nib = {sig_abcd[3:2], sig_abcd[3:2]};
      end
      if (sig_take) begin
         if (slot[4]) begin
            nxt_cur.sig[slot[3:0]][7:4] = nib;
         end else begin
            nxt_cur.sig[slot[3:0]][3:0] = nib;
         end
         irq_set[`IRQ_SIG_UPDATE_BIT] = 1'b1;
      end

      for (int k = 0; k < 5; k++) begin
         if (tally_evt[k]) begin
            if (cur_ff.cnt[k] != 16'hFFFF) begin
               nxt_cur.cnt[k] = cur_ff.cnt[k] + 16'h0001;
            end else begin
               sat_hit = 1'b1;
            end
         end
      end
      irq_set[`IRQ_SATURATE_BIT] = sat_hit;

      nxt_cur.sync_lost_d = sync_lost;
      irq_set[`IRQ_SYNC_LOSS_BIT] = sync_lost & ~cur_ff.sync_lost_d;

      // milliwatt path, phase steps once per frame
      nxt_cur.rx_data_out_valid = rx_data_valid;
      nxt_cur.rx_data_out = rx_data_in;
      if (rx_data_valid) begin
         if (rx_data_channel >= 5'h01 && rx_data_channel <= 5'h18 &&
             cur_ff.mw_en[rx_data_channel - 5'h01]) begin
            nxt_cur.rx_data_out = mw_code(cur_ff.mw_phase);
         end
         if (rx_data_channel == 5'h18) begin
            nxt_cur.mw_phase = cur_ff.mw_phase + 3'h1;
         end
      end

      // read mux
      if (hit) begin
         if (ridx >= `SIG_FIRST_IDX && ridx <= `SIG_LAST_IDX) begin
            rd_byte = cur_ff.sig[4'(ridx - `SIG_FIRST_IDX)];
            if (e1_mode && ridx == `SIG_FIRST_IDX) begin
               rd_byte[7:4] = 4'h0;
            end
            if (!e1_mode && ridx > `SIG_FIRST_IDX + 9'h00B) begin
               rd_byte = 8'h00;
            end
         end else if (ridx >= `LINE_VIOL_HI_IDX && ridx <= `REMOTE_A_LO_IDX) begin
            if (ridx[0]) begin
               rd_byte = cur_ff.lo_shadow;
            end else begin
               rd_byte = cur_ff.cnt[3'(4'(ridx - `LINE_VIOL_HI_IDX) >> 1)][15:8];
            end
         end else begin
            case (ridx)
               `MW_ENABLE_1_IDX: rd_byte = cur_ff.mw_en[7:0];
               `MW_ENABLE_2_IDX: rd_byte = cur_ff.mw_en[15:8];
               `MW_ENABLE_3_IDX: rd_byte = cur_ff.mw_en[23:16];
               `MODE_CTRL_IDX: rd_byte = cur_ff.mode;
               `IRQ_STATUS_IDX: rd_byte = cur_ff.irq_status;
               `IRQ_MASK_IDX: rd_byte = cur_ff.irq_mask;
               default: rd_byte = 8'h00;
            endcase
         end
      end

      // bus handshake: one wait cycle, then a one-cycle acknowledge
      nxt_cur.waitrequest = 1'b1;
      if ((avs_read | avs_write) && cur_ff.waitrequest) begin
         nxt_cur.waitrequest = 1'b0;
         nxt_cur.readdata = {24'h000000, rd_byte};
      end

      // interrupt status: write one to clear, a new event wins
      nxt_cur.irq_status = cur_ff.irq_status;
      if (acc_now && avs_write && hit && ridx == `IRQ_STATUS_IDX && avs_byteenable[0]) begin
         nxt_cur.irq_status = cur_ff.irq_status & ~avs_writedata[7:0];
      end
      nxt_cur.irq_status = nxt_cur.irq_status | irq_set;

      if (acc_now && hit) begin
         if (avs_read && !ridx[0] && ridx >= `LINE_VIOL_HI_IDX &&
             ridx <= `REMOTE_A_HI_IDX) begin
            // capture low byte with the high byte
            nxt_cur.lo_shadow = cur_ff.cnt[3'(4'(ridx - `LINE_VIOL_HI_IDX) >> 1)][7:0];
         end
         if (avs_write && avs_byteenable[0]) begin
            case (ridx)
               `MW_ENABLE_1_IDX: nxt_cur.mw_en[7:0] = avs_writedata[7:0];
               `MW_ENABLE_2_IDX: nxt_cur.mw_en[15:8] = avs_writedata[7:0];
               `MW_ENABLE_3_IDX: nxt_cur.mw_en[23:16] = avs_writedata[7:0];
               `MODE_CTRL_IDX: nxt_cur.mode = avs_writedata[7:0] & 8'h03;
               `IRQ_MASK_IDX: nxt_cur.irq_mask = avs_writedata[7:0] & 8'h07;
               default: nxt_cur.mode = nxt_cur.mode;
            endcase
         end
      end

      nxt_cur.irq = |(nxt_cur.irq_status & nxt_cur.irq_mask);
   end

   // ==================================================
   // state register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_ff.sig <= {16{`SIG_RST}};
         cur_ff.cnt <= {5{`COUNT_RST}};
         cur_ff.mw_en <= 24'h000000;
         cur_ff.mode <= `MODE_CTRL_RST;
         cur_ff.irq_status <= 8'h00;
         cur_ff.irq_mask <= `IRQ_MASK_RST;
         cur_ff.lo_shadow <= 8'h00;
         cur_ff.mw_phase <= 3'h0;
         cur_ff.readdata <= 32'h00000000;
         cur_ff.waitrequest <= 1'b1;
         cur_ff.irq <= 1'b0;
         cur_ff.rx_data_out <= 8'h00;
         cur_ff.rx_data_out_valid <= 1'b0;
         cur_ff.sync_lost_d <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ==================================================
   // outputs straight from flops
   assign avs_readdata = cur_ff.readdata;
   assign avs_waitrequest = cur_ff.waitrequest;
   assign irq = cur_ff.irq;
   assign rx_data_out = cur_ff.rx_data_out;
   assign rx_data_out_valid = cur_ff.rx_data_out_valid;

endmodule

`default_nettype wire

// [testbench/rx_sig_counters_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// port-level checks
module rx_sig_counters_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic rx_data_valid,
   input wire logic rx_data_out_valid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_ack;
      s_req |=> s_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("access not answered in one cycle");
   property p_idle;
      !(avs_read || avs_write) |=> avs_waitrequest;
   endproperty
   a_idle: assert property (p_idle)
      else $error("waitrequest low without access");
   property p_cause;
      !avs_waitrequest |-> $past(avs_read || avs_write);
   endproperty
   a_cause: assert property (p_cause)
      else $error("answer without request");
   property p_upper;
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper read bytes not zero");
   property p_hold;
      !(avs_read || avs_write) |=> $stable(avs_readdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved while idle");
   property p_rst;
      $fell(sys_rst) |-> avs_readdata == 32'h00000000 && !irq && avs_waitrequest;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not at reset values");
   property p_mw_lat;
      rx_data_valid |=> rx_data_out_valid;
   endproperty
   a_mw_lat: assert property (p_mw_lat)
      else $error("receive byte not passed on");
   property p_mw_quiet;
      !rx_data_valid |=> !rx_data_out_valid;
   endproperty
   a_mw_quiet: assert property (p_mw_quiet)
      else $error("receive byte without input");
endmodule
`default_nettype wire

// [testbench/remote_term_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// far terminal as seen after the framer
module remote_term_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic req_sig,
   input wire logic [4:0] req_ch,
   input wire logic [3:0] req_abcd,
   input wire logic [4:0] req_evt,
   output logic sig_valid,
   output logic [4:0] sig_channel,
   output logic [3:0] sig_abcd,
   output logic [4:0] evt
);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sig_valid <= 1'h0;
         sig_channel <= 5'h00;
         sig_abcd <= 4'h0;
         evt <= 5'h00;
      end else begin
         sig_valid <= req_sig;
         // idle lines toggle so stale values are never trusted
         sig_channel <= req_sig ? req_ch : ~sig_channel;
         sig_abcd <= req_sig ? req_abcd : ~sig_abcd;
         evt <= req_evt;
      end
   end
endmodule
`default_nettype wire

// [testbench/t1e1_rx_signaling_and_error_counters_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rx_sig_counters_cfg.svh"
// ==========
// bench
module t1e1_rx_signaling_and_error_counters_tb_top;
   localparam logic [2:0] PA = 3'h3;
   logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, irq, sig_valid, req_sig;
   logic rx_data_valid, rx_data_out_valid, sync_lost;
   logic [13:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdv;
   logic [3:0] avs_byteenable, req_abcd, sig_abcd;
   logic [4:0] req_ch, req_evt, evt, sig_channel, rx_data_channel;
   logic [7:0] rx_data_in, rx_data_out, mode;
   logic [23:0] mwe;
   logic [3:0] sg[32];
   logic [7:0] code[8] = '{`MW_CODE_0, `MW_CODE_1, `MW_CODE_2, `MW_CODE_3,
                           `MW_CODE_4, `MW_CODE_5, `MW_CODE_6, `MW_CODE_7};
   int bad_count, checks, ph, cnt[5];
   rx_sig_counters #(.PORT_ID(3)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .sig_valid(sig_valid), .sig_channel(sig_channel), .sig_abcd(sig_abcd),
      .sync_lost(sync_lost), .line_violation_evt(evt[0]), .path_violation_evt(evt[1]),
      .frame_slip_evt(evt[2]), .far_error_bit_evt(evt[3]), .remote_error_a_evt(evt[4]),
      .rx_data_valid(rx_data_valid), .rx_data_channel(rx_data_channel),
      .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
      .rx_data_out_valid(rx_data_out_valid));
   remote_term_model far_u (.mclk(mclk), .sys_rst(sys_rst), .req_sig(req_sig),
      .req_ch(req_ch), .req_abcd(req_abcd), .req_evt(req_evt), .sig_valid(sig_valid),
      .sig_channel(sig_channel), .sig_abcd(sig_abcd), .evt(evt));
   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [11:0] adr, input logic [7:0] wd);
      int t;
      logic w;
      @(posedge mclk);
      avs_address <= {adr, 2'h0};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h000000, wd};
      t = 0;
      // settled values, taken before the edge that completes the access
      do begin
         @(negedge mclk);
         w = avs_waitrequest;
         rdv = avs_readdata;
         @(posedge mclk);
         t++;
      end while (w !== 1'h0 && t < 40);
      if (t >= 40) bad_count++;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] adr, input logic [7:0] exp);
      bus(1'h0, adr, 8'h00);
      chk(rdv, {24'h000000, exp});
   endtask
   task automatic setm(input logic [7:0] m);
      mode = m;
      bus(1'h1, {PA, 9'h070}, m);
   endtask
   task automatic sig(input logic [4:0] ch, input logic [3:0] v);
      @(posedge mclk);
      req_sig <= 1'h1;
      req_ch <= ch;
      req_abcd <= v;
      @(posedge mclk);
      req_sig <= 1'h0;
      if (sync_lost !== 1'h1) sg[ch] = (mode == 8'h00) ? {v[3:2], v[3:2]} : v;
   endtask
   function automatic logic [7:0] se(input int k);
      if (mode[0]) return (k == 1) ? {4'h0, sg[0]} : {sg[k-1], sg[k+14]};
      return (k <= 12) ? {sg[k], sg[k+12]} : 8'h00;
   endfunction
   task automatic rsig;
      for (int k = 1; k <= 16; k++) rd({PA, 9'h03F + 9'(k)}, se(k));
   endtask
   task automatic sigs(input int lo, input int hi);
      for (int c = lo; c <= hi; c++) sig(5'(c), 4'($urandom));
   endtask
   // saturating model count; far error bits only counted in e1
   task automatic pulse(input int i, input int len);
      @(posedge mclk);
      req_evt[i] <= 1'h1;
      repeat (len) @(posedge mclk);
      req_evt[i] <= 1'h0;
      if (i != 3 || mode[0]) cnt[i] = (cnt[i] + len > 65535) ? 65535 : cnt[i] + len;
   endtask
   task automatic rcnt;
      for (int i = 0; i < 5; i++) begin
         rd({PA, 9'h050 + 9'(2 * i)}, 8'(cnt[i] >> 8));
         rd({PA, 9'h051 + 9'(2 * i)}, 8'(cnt[i]));
      end
   endtask
   initial begin
      #800000;
      bad_count++;
      end_sim();
   end
   initial begin
      void'($urandom(71582));
      {sys_rst, avs_byteenable} = {1'h1, 4'hF};
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {req_sig, req_ch, req_abcd, req_evt, sync_lost, mode, mwe} = '0;
      {rx_data_valid, rx_data_channel, rx_data_in} = '0;
      {bad_count, checks, ph} = '0;
      cnt = '{default: 0};
      sg = '{default: 4'h0};
      repeat (8) @(posedge mclk);
      sys_rst <= 1'h0;
      bus(1'h1, {PA, 9'h050}, 8'hFF);
      bus(1'h1, {3'h5, 9'h070}, 8'h01);
      for (int k = 'h40; k <= 'h5A; k++) rd({PA, 9'(k)}, 8'h00);
      sigs(1, 24);
      // host reads the whole store right after each burst of updates
      rsig();
      setm(8'h02);
      sigs(1, 24);
      rsig();
      for (int i = 0; i < 5; i++) pulse(i, 1 + $urandom % 40);
      rcnt();
      setm(8'h01);
      sigs(0, 30);
      rsig();
      pulse(3, 1 + $urandom % 40);
      rcnt();
      bus(1'h1, {PA, 9'h071}, 8'hFF);
      bus(1'h1, {PA, 9'h072}, 8'h02);
      sync_lost <= 1'h1;
      sigs(0, 30);
      chk(irq, 1'h1);
      rsig();
      bus(1'h1, {PA, 9'h072}, 8'h00);
      repeat (3) @(posedge mclk);
      chk(irq, 1'h0);
      bus(1'h1, {PA, 9'h071}, 8'h02);
      bus(1'h1, {PA, 9'h072}, 8'h02);
      repeat (3) @(posedge mclk);
      chk(irq, 1'h0);
      sync_lost <= 1'h0;
      setm(8'h00);
      mwe = 24'($urandom);
      for (int j = 0; j < 3; j++) bus(1'h1, {PA, 9'h03C + 9'(j)}, mwe[8*j +: 8]);
      for (int f = 0; f < 2; f++) begin
         for (int c = 1; c <= 24; c++) begin
            @(posedge mclk);
            rx_data_valid <= 1'h1;
            rx_data_channel <= 5'(c);
            rx_data_in <= 8'($urandom);
            @(posedge mclk);
            rx_data_valid <= 1'h0;
            #1 chk(rx_data_out, mwe[c-1] ? code[ph] : rx_data_in);
         end
         ph = (ph + 1) % 8;
      end
      pulse(4, 65600);
      rcnt();
      end_sim();
   end
endmodule
bind rx_sig_counters rx_sig_counters_checker chk_u (.mclk(mclk), .sys_rst(sys_rst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq(irq), .rx_data_valid(rx_data_valid),
   .rx_data_out_valid(rx_data_out_valid));
`default_nettype wire
